// [rtl/msc_defines.svh]
`ifndef MSC_DEFINES_SVH
`define MSC_DEFINES_SVH
// ----------------------------------------
// register addresses (7-bit serial address)
// ----------------------------------------
`define MSC_ADDR_MS        7'h01
`define MSC_ADDR_HW        7'h02
// ----------------------------------------
// field encodings and masks
// ----------------------------------------
`define MSC_MODE_NORMAL    2'h0
`define MSC_MODE_SLEEP     2'h1
`define MSC_MODE_STOP      2'h2
`define MSC_MODE_SOFT      2'h3
`define MSC_MS_RESET       8'h00
`define MSC_MS_RESTART_KEEP 8'h23
`define MSC_HW_RESET       8'h00
`define MSC_HW_RESTART_KEEP 8'hd9
`define MSC_HW_SOFT_KEEP   8'h88
`define MSC_HW_WRITE_MASK  8'hfb
`define MSC_WD_ESC_FIRST   2'h1
`define MSC_WD_ESC_SECOND  2'h2
// ----------------------------------------
// timing
// ----------------------------------------
`define MSC_CLK_NS         100
`define MSC_RO_PULSE_NS    500
`define MSC_RO_PULSE_CYC   ((`MSC_RO_PULSE_NS + `MSC_CLK_NS - 1) / `MSC_CLK_NS)
`define MSC_FRAME_BITS     5'h10
`define MSC_CNT_OVER       5'h11
`define MSC_PIN_IDLE       3'h4
`endif

// [rtl/msc_frame_if.sv]
`timescale 1ns/100ps
// ----------------------------------------
// serial frame carrier between shifter and registers
// ----------------------------------------
interface msc_frame_if;
  logic       done;       // one-cycle pulse, full 16-bit frame ended
  logic       wr;         // access bit of the frame
  logic [6:0] addr;       // register address
  logic [7:0] data;       // data byte
  logic       addr_seen;  // one-cycle pulse, address byte complete
  logic [7:0] reply;      // byte to shift back in the data phase
  modport shifter (output done, output wr, output addr, output data,
                   output addr_seen, input reply);
  modport regs    (input done, input wr, input addr, input data,
                   input addr_seen, output reply);
endinterface : msc_frame_if

// [rtl/msc_mode_supply_regs.sv]
`timescale 1ns/100ps
`include "msc_defines.svh"

// Function
// RULE_01 - mode field: normal, sleep, stop, soft reset
// RULE_02 - stop to sleep write is refused
// RULE_03 - restart sets mode field to normal
// RULE_04 - restart or overtemperature clears second regulator field
// RULE_05 - bit five switches third regulator on
// RULE_06 - second regulator field selects its on modes
// RULE_07 - overvoltage reaction bit enables escalation
// RULE_08 - two bits select main reset threshold
// RULE_09 - mode register resets zero, restart keeps few
// RULE_10 - write frame returns previous register content
// RULE_11 - voltage bit selects third regulator level
// RULE_12 - suppress bit keeps reset output released
// RULE_13 - software bit turns failure outputs on
// RULE_14 - failure flag, not bit, ends failure outputs
// RULE_15 - undervoltage bit keeps third regulator running
// RULE_16 - bit three selects load sharing operation
// RULE_17 - stop bit enables load sharing in stop
// RULE_18 - config bit picks first or second escalation
// RULE_19 - reserved hardware bit reads zero
// RULE_20 - restart keeps selected hardware control bits
// RULE_21 - host sends address, access bit, data byte
// RULE_22 - restart clears software failure output bit
// RULE_23 - soft reset keeps voltage and sharing bits
// RULE_24 - written fields hold until rewrite or reset
module msc_mode_supply_regs (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             reset,
  // serial link pins
  input  wire logic             csn_n,
  input  wire logic             sclk,
  input  wire logic             sdi,
  output      logic             sdo_out,
  output      logic             sdo_oe_n,
  // chip events and conditions
  input  wire logic             restart_entry,
  input  wire logic             overtemp_event,
  input  wire logic             main_overvoltage,
  input  wire logic             fail_safe_active,
  input  wire logic             supply_undervoltage,
  input  wire logic             high_power_mode,
  input  wire logic             failure_status,
  // requested mode and reset control
  output msc_pkg::msc_mode_t    chip_mode,
  output      logic             soft_reset_pulse,
  output      logic             reset_output_low,
  // supply control
  output      logic             second_regulator_on,
  output      logic             third_regulator_on,
  output      logic             third_regulator_voltage_sel,
  output      logic             third_reg_load_sharing,
  output      logic [1:0]       main_reset_threshold,
  output      logic             main_overvoltage_flag,
  output      logic             main_ov_escalate,
  // failure handling
  output      logic             failure_outputs,
  output      logic [1:0]       wd_fail_escalate_count
);
  import msc_pkg::*;

  // ----------------------------------------
  // frame path
  // ----------------------------------------
  msc_frame_if frame ();          // shifter to register carrier
  logic [2:0]  pins_clean;        // {csn_n, sclk, sdi} after filter

  // pins from the far side cross with three flops
  msc_pin_sync #(
    .W    (3),
    .IDLE (`MSC_PIN_IDLE)
  ) u_sync (
    .ref_clk (ref_clk),
    .reset   (reset),
    .pin     ({csn_n, sclk, sdi}),
    .clean   (pins_clean)
  );

  // host sends address, access bit and data in one frame
  msc_spi_shift u_shift (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .csn_n_s  (pins_clean[2]),
    .sclk_s   (pins_clean[1]),
    .sdi_s    (pins_clean[0]),
    .sdo_out  (sdo_out),
    .sdo_oe_n (sdo_oe_n),
    .frame    (frame)
  );

  // ----------------------------------------
  // register state
  // ----------------------------------------
  msc_byte_t     mode_and_supply_control;   // mode and supply register
  msc_byte_t     hardware_config_control;   // hardware control register
  msc_byte_t     next_ms;                   // next mode and supply value
  msc_byte_t     next_hw;                   // next hardware value
  msc_ro_state_t ro_state;                  // reset output sequence
  msc_ro_state_t next_ro_state;
  logic [2:0]    ro_cnt;                    // reset output hold count
  logic [2:0]    next_ro_cnt;

  // ----------------------------------------
  // field views
  // ----------------------------------------
  wire [1:0] mode_field   = mode_and_supply_control[7:6];
  wire       third_enable = mode_and_supply_control[5];
  wire [1:0] second_regulator_mode = mode_and_supply_control[4:3];
  wire       main_ov_reaction_enable = mode_and_supply_control[2];
  wire       third_reg_undervolt_keep_on = hardware_config_control[4];
  wire       soft_reset_output_suppress = hardware_config_control[6];
  wire       failure_output_sw_activate = hardware_config_control[5];
  wire       load_sharing_stop_enable = hardware_config_control[1];
  wire       cfg_first_fail = hardware_config_control[0];

  // ----------------------------------------
  // write decode
  // ----------------------------------------
  wire       frame_write = frame.done & frame.wr;       // [RULE_21]
  wire       wr_ms = frame_write & (frame.addr == `MSC_ADDR_MS);
  wire       wr_hw = frame_write & (frame.addr == `MSC_ADDR_HW);
  wire [1:0] wr_mode = frame.data[7:6];
  // soft reset code executes instead of storing
  wire       soft_cmd = wr_ms & (wr_mode == `MSC_MODE_SOFT);        // [RULE_01]
  // stop to sleep is not a legal software move
  wire       stop_to_sleep = (mode_field == `MSC_MODE_STOP) &
                             (wr_mode == `MSC_MODE_SLEEP);          // [RULE_02]
  wire [7:0] ms_write_val = stop_to_sleep ? {mode_field, frame.data[5:0]}
                                          : frame.data;             // [RULE_02]

  // ----------------------------------------
  // readback, old content during a write
  // ----------------------------------------
  wire [7:0] rd_ms = mode_and_supply_control;
  wire [7:0] rd_hw = hardware_config_control & `MSC_HW_WRITE_MASK;  // [RULE_19]
  assign frame.reply = (frame.addr == `MSC_ADDR_MS) ? rd_ms :
                       (frame.addr == `MSC_ADDR_HW) ? rd_hw : 8'h00; // [RULE_10]

  // ----------------------------------------
  // next mode and supply value
  // ----------------------------------------
  // priority: soft reset, restart, overtemperature, host write
  always_comb begin
    next_ms = mode_and_supply_control;                        // [RULE_24]
    if (wr_ms) begin
      next_ms = ms_write_val;
    end
    if (overtemp_event) begin
      next_ms[4:3] = 2'h0;                                    // [RULE_04]
    end
    if (restart_entry) begin
      // mode falls to normal, regulator two to off
      next_ms = mode_and_supply_control & `MSC_MS_RESTART_KEEP; // [RULE_03] [RULE_04] [RULE_09]
    end
    if (soft_cmd) begin
      next_ms = `MSC_MS_RESET;                                // [RULE_09]
    end
  end

  // ----------------------------------------
  // next hardware control value
  // ----------------------------------------
  always_comb begin
    next_hw = hardware_config_control;                        // [RULE_24]
    if (wr_hw) begin
      next_hw = frame.data & `MSC_HW_WRITE_MASK;              // [RULE_19]
    end
    if (restart_entry) begin
      // drops the software failure output bit too
      next_hw = hardware_config_control & `MSC_HW_RESTART_KEEP; // [RULE_20] [RULE_22]
    end
    if (soft_cmd) begin
      next_hw = hardware_config_control & `MSC_HW_SOFT_KEEP;  // [RULE_23]
    end
  end

  // register update
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mode_and_supply_control <= `MSC_MS_RESET;               // [RULE_09]
      hardware_config_control <= `MSC_HW_RESET;
    end else begin
      mode_and_supply_control <= next_ms;
      hardware_config_control <= next_hw;
    end
  end

  // ----------------------------------------
  // soft reset and reset output sequence
  // ----------------------------------------
  // the suppress bit is read before the soft reset clears it
  always_comb begin
    next_ro_state = ro_state;
    next_ro_cnt   = ro_cnt;
    case (ro_state)
      msc_ro_idle: begin
        if (soft_cmd && !soft_reset_output_suppress) begin  // [RULE_12]
          next_ro_state = msc_ro_hold;
          next_ro_cnt   = 3'(`MSC_RO_PULSE_CYC - 1);
        end
      end
      msc_ro_hold: begin
        if (ro_cnt == 3'h0) begin
          next_ro_state = msc_ro_idle;
        end else begin
          next_ro_cnt = ro_cnt - 3'h1;
        end
      end
      default: begin
        next_ro_state = msc_ro_idle;
      end
    endcase
  end

  // sequence state
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ro_state <= msc_ro_idle;
      ro_cnt   <= 3'h0;
    end else begin
      ro_state <= next_ro_state;
      ro_cnt   <= next_ro_cnt;
    end
  end

  // ----------------------------------------
  // supply and failure decode
  // ----------------------------------------
  wire in_normal = (mode_field == `MSC_MODE_NORMAL);
  wire in_stop   = (mode_field == `MSC_MODE_STOP);
  wire next_second_on =
    (second_regulator_mode == 2'h1) ? in_normal :
    (second_regulator_mode == 2'h2) ? (in_normal | in_stop) :
    (second_regulator_mode == 2'h3) ? ~fail_safe_active : 1'b0;    // [RULE_06]
  // undervoltage shutdown unless told to keep running
  wire uv_off    = supply_undervoltage & ~third_reg_undervolt_keep_on; // [RULE_15]
  // load sharing may be parked in stop and high power mode
  wire ls_park   = hardware_config_control[3] & (in_stop | high_power_mode) &
                   ~load_sharing_stop_enable;                      // [RULE_16] [RULE_17]
  wire next_third_on = third_enable & ~uv_off & ~ls_park;          // [RULE_05]
  // failure flag keeps outputs on after the software bit clears
  wire next_fail_out = failure_output_sw_activate | failure_status; // [RULE_13] [RULE_14]
  wire [1:0] next_wd_count = cfg_first_fail ? `MSC_WD_ESC_FIRST
                                            : `MSC_WD_ESC_SECOND;  // [RULE_18]

  // registered control outputs
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      chip_mode <= `MSC_MODE_NORMAL; soft_reset_pulse <= 1'b0;
      reset_output_low <= 1'b0; second_regulator_on <= 1'b0;
      third_regulator_on <= 1'b0; third_regulator_voltage_sel <= 1'b0;
      third_reg_load_sharing <= 1'b0; main_reset_threshold <= 2'h0;
      main_overvoltage_flag <= 1'b0; main_ov_escalate <= 1'b0;
      failure_outputs <= 1'b0; wd_fail_escalate_count <= `MSC_WD_ESC_SECOND;
    end else begin
      chip_mode <= mode_field;                                     // [RULE_01]
      soft_reset_pulse <= soft_cmd;                                // [RULE_01]
      reset_output_low <= (next_ro_state == msc_ro_hold);          // [RULE_12]
      second_regulator_on <= next_second_on;
      third_regulator_on <= next_third_on;
      third_regulator_voltage_sel <= hardware_config_control[7];   // [RULE_11]
      third_reg_load_sharing <= hardware_config_control[3];        // [RULE_16]
      main_reset_threshold <= mode_and_supply_control[1:0];        // [RULE_08]
      main_overvoltage_flag <= main_overvoltage;                   // [RULE_07]
      main_ov_escalate <= main_overvoltage & main_ov_reaction_enable; // [RULE_07]
      failure_outputs <= next_fail_out;
      wd_fail_escalate_count <= next_wd_count;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence s_soft_cmd;
    wr_ms && (frame.data[7:6] == 2'h3);
  endsequence

  sequence s_ro_hold;
    reset_output_low [*5] ##1 !reset_output_low;
  endsequence

  property p_soft_clears;
    s_soft_cmd |=> (mode_and_supply_control == 8'h00) &&
                   ((hardware_config_control & 8'h77) == 8'h00);
  endproperty
  a_soft_clears: assert property (p_soft_clears) // [RULE_09] [RULE_23]
    else $error("soft reset did not clear registers");

  property p_no_stop_sleep;
    (mode_field == 2'h2) && wr_ms && (frame.data[7:6] == 2'h1) &&
      !restart_entry |=> (mode_field == 2'h2);
  endproperty
  a_no_stop_sleep: assert property (p_no_stop_sleep) // [RULE_02]
    else $error("stop to sleep write was accepted");

  property p_restart_ms;
    restart_entry && !soft_cmd |=>
      mode_and_supply_control == ($past(mode_and_supply_control) & 8'h23);
  endproperty
  a_restart_ms: assert property (p_restart_ms) // [RULE_03]
    else $error("restart value of mode register wrong");

  property p_ot_clears_second;
    overtemp_event |=> (second_regulator_mode == 2'h0) ##1 !second_regulator_on;
  endproperty
  a_ot_clears_second: assert property (p_ot_clears_second) // [RULE_04]
    else $error("overtemperature left second regulator on");

  property p_restart_hw;
    restart_entry && !soft_cmd |=>
      hardware_config_control == ($past(hardware_config_control) & 8'hd9);
  endproperty
  a_restart_hw: assert property (p_restart_hw) // [RULE_20]
    else $error("restart value of hardware register wrong");

  property p_ro_pulse;
    s_soft_cmd ##0 (!soft_reset_output_suppress && ro_state == msc_ro_idle)
      |=> s_ro_hold;
  endproperty
  a_ro_pulse: assert property (p_ro_pulse) // [RULE_12]
    else $error("reset output pulse length wrong");

  property p_failure_holds;
    failure_status ##1 failure_status |-> failure_outputs;
  endproperty
  a_failure_holds: assert property (p_failure_holds) // [RULE_14]
    else $error("failure outputs dropped while failure flag set");

  property p_wd_count;
    ##1 wd_fail_escalate_count == ($past(cfg_first_fail) ? 2'h1 : 2'h2);
  endproperty
  a_wd_count: assert property (p_wd_count) // [RULE_18]
    else $error("watchdog escalation count wrong");

  property p_reserved_zero;
    frame.addr == 7'h02 |-> frame.reply[2] == 1'b0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) // [RULE_19]
    else $error("reserved bit read as one");
endmodule : msc_mode_supply_regs

// [rtl/msc_pin_sync.sv]
`timescale 1ns/100ps
// ----------------------------------------
// three-stage pin synchroniser with agreement filter
// ----------------------------------------
module msc_pin_sync #(
  parameter int unsigned W = 3,
  parameter logic [W-1:0] IDLE = '0
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         reset,
  // pins and clean copies
  input  wire logic [W-1:0] pin,
  output      logic [W-1:0] clean
);
  logic [W-1:0] s1;  // metastable stage, read by s2 only
  logic [W-1:0] s2;  // second stage
  logic [W-1:0] s3;  // third stage
  // a change counts once stages two and three agree
  wire  [W-1:0] next_clean = (s3 & ~(s2 ^ s3)) | (clean & (s2 ^ s3));

  // synchroniser chain
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s1    <= IDLE;
      s2    <= IDLE;
      s3    <= IDLE;
      clean <= IDLE;
    end else begin
      s1    <= pin;
      s2    <= s1;
      s3    <= s2;
      clean <= next_clean;
    end
  end
endmodule : msc_pin_sync

// [rtl/msc_pkg.sv]
// ----------------------------------------
// shared types
// ----------------------------------------
package msc_pkg;
  typedef logic [1:0] msc_mode_t;   // chip mode field
  typedef logic [7:0] msc_byte_t;   // one register byte
  typedef enum { msc_ro_idle, msc_ro_hold } msc_ro_state_t;
endpackage : msc_pkg

// [rtl/msc_spi_shift.sv]
`timescale 1ns/100ps
`include "msc_defines.svh"
// ----------------------------------------
// 16-bit serial frame shifter, lsb first
// ----------------------------------------
module msc_spi_shift (
  // clock and reset
  input  wire logic   ref_clk,
  input  wire logic   reset,
  // synchronised pins
  input  wire logic   csn_n_s,
  input  wire logic   sclk_s,
  input  wire logic   sdi_s,
  // serial output, enable low while driving
  output      logic   sdo_out,
  output      logic   sdo_oe_n,
  // frame carrier
  msc_frame_if.shifter frame
);
  import msc_pkg::*;
  logic [15:0] rx;        // received bits, bit n at index n
  logic [4:0]  cnt;       // bits seen; over-count parks at MSC_CNT_OVER
  logic        sclk_d;    // previous clock level
  logic        csn_d;     // previous select level
  msc_byte_t   tx;        // reply byte
  wire rise    = sclk_s & ~sclk_d & ~csn_n_s;
  wire fall    = ~sclk_s & sclk_d & ~csn_n_s;
  wire sel_beg = ~csn_n_s & csn_d;
  wire sel_end = csn_n_s & ~csn_d;
  wire data_ph = cnt[3] & ~cnt[4];
  assign frame.addr = rx[6:0];
  assign frame.wr   = rx[7];
  assign frame.data = rx[15:8];

  // shift, count and frame strobes
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rx <= 16'h0000; cnt <= 5'h00; sclk_d <= 1'b0; csn_d <= 1'b1;
      tx <= 8'h00; sdo_out <= 1'b0; sdo_oe_n <= 1'b1;
      frame.done <= 1'b0; frame.addr_seen <= 1'b0;
    end else begin
      sclk_d <= sclk_s;
      csn_d  <= csn_n_s;
      sdo_oe_n <= csn_n_s;
      frame.done <= sel_end & (cnt == `MSC_FRAME_BITS);
      frame.addr_seen <= rise & (cnt == 5'h07);
      if (sel_beg) begin
        cnt <= 5'h00;
        sdo_out <= 1'b0;
      end else if (rise && cnt != `MSC_CNT_OVER) begin
        rx[cnt[3:0]] <= (cnt[4]) ? rx[cnt[3:0]] : sdi_s;
        cnt <= cnt + 5'h01;
      end
      if (frame.addr_seen) tx <= frame.reply;
      // old content goes out while the new byte comes in
      if (fall) sdo_out <= data_ph ? tx[cnt[2:0]] : 1'b0;  // [RULE_10]
    end
  end
endmodule : msc_spi_shift

// [sim/msc_host_model.sv]
`timescale 1ns/100ps
// ----------------------------------------
// host end of the 16-bit serial link
// ----------------------------------------
module msc_host_model (
  // clock
  input  wire logic ref_clk,
  // link pins
  output      logic csn_n,
  output      logic sclk,
  output      logic sdi,
  input  wire logic sdo_out,
  input  wire logic sdo_oe_n
);
  import msc_pkg::*;
  // deselected, link clock parked low outside frames
  initial begin
    csn_n = 1'b1;
    sclk  = 1'b0;
    sdi   = 1'b0;
  end
  // wait a number of ref_clk edges
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc
  // one frame, lsb first, 800 ns link period
  task automatic xfer(input logic wr, input logic [6:0] addr, input msc_byte_t data,
                      output msc_byte_t rd);
    logic [15:0] f;
    f  = {data, wr, addr};
    rd = 8'h00;
    cyc(1);
    csn_n <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      sdi <= f[i];
      cyc(4);
      sclk <= 1'b1;
      cyc(4);
      // sample late in the high phase: sdo moves only after a fall
      if (i > 7) rd[i-8] = (sdo_oe_n === 1'b0) ? sdo_out : 1'bx;
      sclk <= 1'b0;
    end
    cyc(4);
    csn_n <= 1'b1;
    sdi   <= ~f[15];  // released line must not look like held data
    cyc(12);
  endtask : xfer
endmodule : msc_host_model

// [sim/tb_top.sv]
`timescale 1ns/100ps
`include "msc_defines.svh"
module tb_top;
  import msc_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic       ref_clk, reset, csn_n, sclk, sdi, sdo_out, sdo_oe_n;
  logic       restart_entry, overtemp_event, main_overvoltage, fail_safe_active;
  logic       supply_undervoltage, high_power_mode, failure_status;
  msc_mode_t  chip_mode;
  logic       soft_reset_pulse, reset_output_low, second_regulator_on;
  logic       third_regulator_on, third_regulator_voltage_sel, third_reg_load_sharing;
  logic       main_overvoltage_flag, main_ov_escalate, failure_outputs;
  logic [1:0] main_reset_threshold, wd_fail_escalate_count;
  int         fails, total_checks, cycles, pulses, low_cyc;
  msc_byte_t  r;
  // ----------------------------------------
  // clock, instances, monitors
  // ----------------------------------------
  initial ref_clk = 1'b0;
  always #50 ref_clk = ~ref_clk;
  msc_mode_supply_regs msc_mode_supply_regs_inst (.ref_clk, .reset, .csn_n, .sclk, .sdi,
    .sdo_out, .sdo_oe_n, .restart_entry, .overtemp_event, .main_overvoltage,
    .fail_safe_active, .supply_undervoltage, .high_power_mode, .failure_status,
    .chip_mode, .soft_reset_pulse, .reset_output_low, .second_regulator_on,
    .third_regulator_on, .third_regulator_voltage_sel, .third_reg_load_sharing,
    .main_reset_threshold, .main_overvoltage_flag, .main_ov_escalate, .failure_outputs,
    .wd_fail_escalate_count);
  msc_host_model host_inst (.ref_clk, .csn_n, .sclk, .sdi, .sdo_out, .sdo_oe_n);
  // pulse and reset-output widths, plus hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (soft_reset_pulse === 1'b1) pulses++;
    if (reset_output_low === 1'b1) low_cyc++;
    if (cycles == 20000) begin
      fails++;
      tally_and_finish();
    end
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk_byte(input msc_byte_t got, input msc_byte_t exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk_byte
  task automatic chk_bit(input logic got, input logic exp);
    chk_byte({7'h00, got}, {7'h00, exp});
  endtask : chk_bit
  task automatic set_supply(input logic v);
    fail_safe_active    <= v;
    supply_undervoltage <= v;
  endtask : set_supply
  task automatic wr(input logic [6:0] a, input msc_byte_t d);
    host_inst.xfer(1'b1, a, d, r);
  endtask : wr
  task automatic rd(input logic [6:0] a, input msc_byte_t e);
    host_inst.xfer(1'b0, a, 8'h00, r);
    chk_byte(r, e);
  endtask : rd
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    rd(`MSC_ADDR_MS, 8'h00);
    chk_byte({6'h00, wd_fail_escalate_count}, 8'h02);
    host_inst.xfer(1'b1, `MSC_ADDR_MS, 8'h04, r);
    chk_byte(r, 8'h00);
    main_overvoltage <= 1'b1;
    host_inst.cyc(3);
    chk_bit(main_ov_escalate, 1'b1);
    wr(`MSC_ADDR_MS, 8'h00);
    chk_bit(main_overvoltage_flag, 1'b1);
    chk_bit(main_ov_escalate, 1'b0);
    main_overvoltage <= 1'b0;
  endtask : t_reset
  task automatic t_fields();
    for (int i = 0; i < 4; i++) begin
      wr(`MSC_ADDR_MS, {3'b001, i[1:0], 1'b0, i[1:0]});
      chk_bit(second_regulator_on, i != 0);
      chk_byte({6'h00, main_reset_threshold}, i[7:0]);
      chk_bit(third_regulator_on, 1'b1);
    end
    set_supply(1'b1);
    host_inst.cyc(3);
    chk_bit(second_regulator_on, 1'b0);
    chk_bit(third_regulator_on, 1'b0);
    wr(`MSC_ADDR_HW, 8'h10);
    chk_bit(third_regulator_on, 1'b1);
    set_supply(1'b0);
    wr(`MSC_ADDR_HW, 8'h18);
    wr(`MSC_ADDR_MS, 8'ha0);
    chk_bit(third_regulator_on, 1'b0);
    wr(`MSC_ADDR_HW, 8'h1a);
    chk_bit(third_regulator_on, 1'b1);
    chk_bit(third_reg_load_sharing, 1'b1);
    wr(`MSC_ADDR_MS, 8'h61);
    rd(`MSC_ADDR_MS, 8'ha1);
    wr(7'h05, 8'hff);
    rd(7'h05, 8'h00);
    rd(`MSC_ADDR_HW, 8'h1a);
  endtask : t_fields
  // restart leaves only the kept bits
  task automatic t_restart();
    wr(`MSC_ADDR_MS, 8'h7f);
    wr(`MSC_ADDR_HW, 8'hff);
    rd(`MSC_ADDR_HW, 8'hfb);
    chk_bit(failure_outputs, 1'b1);
    chk_byte({6'h00, wd_fail_escalate_count}, 8'h01);
    chk_bit(third_regulator_voltage_sel, 1'b1);
    restart_entry <= 1'b1;
    host_inst.cyc(1);
    restart_entry <= 1'b0;
    host_inst.cyc(3);
    chk_byte({6'h00, chip_mode}, 8'h00);
    chk_bit(failure_outputs, 1'b0);
    rd(`MSC_ADDR_MS, 8'h23);
    rd(`MSC_ADDR_HW, 8'hd9);
    for (int h = 1; h >= 0; h--) begin
      high_power_mode <= h[0];
      host_inst.cyc(3);
      chk_bit(third_regulator_on, ~h[0]);
    end
    wr(`MSC_ADDR_MS, 8'h18);
    overtemp_event <= 1'b1;
    host_inst.cyc(1);
    overtemp_event <= 1'b0;
    rd(`MSC_ADDR_MS, 8'h00);
  endtask : t_restart
  // failure flag keeps outputs on after the software bit clears
  task automatic t_failure();
    wr(`MSC_ADDR_HW, 8'h20);
    failure_status <= 1'b1;
    wr(`MSC_ADDR_HW, 8'h00);
    chk_bit(failure_outputs, 1'b1);
    failure_status <= 1'b0;
    host_inst.cyc(3);
    chk_bit(failure_outputs, 1'b0);
  endtask : t_failure
  // soft reset with and without reset-output suppression
  task automatic t_soft();
    for (int s = 0; s < 2; s++) begin
      wr(`MSC_ADDR_HW, {1'b1, s[0], 6'h09});
      pulses = 0;
      low_cyc = 0;
      wr(`MSC_ADDR_MS, 8'hc3);
      host_inst.cyc(10);
      chk_byte(pulses[7:0], 8'h01);
      chk_byte(low_cyc[7:0], s ? 8'h00 : 8'h05);
      rd(`MSC_ADDR_MS, 8'h00);
      rd(`MSC_ADDR_HW, 8'h88);
    end
  endtask : t_soft
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {reset, restart_entry, overtemp_event, main_overvoltage, fail_safe_active} = 5'h10;
    {supply_undervoltage, high_power_mode, failure_status} = 3'h0;
    {fails, total_checks, cycles, pulses, low_cyc} = '0;
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    host_inst.cyc(6);
    t_reset();
    t_fields();
    t_restart();
    t_failure();
    t_soft();
    tally_and_finish();
  end
endmodule : tb_top
